/* File: ext_pin_model.sv */
// Purpose: far-side model of the nine timer channel pins
// Assumes: each pin has a pull-up and an optional outside driver
// Notes: a pin nobody drives floats high through its pull-up
`timescale 1ns/1ps
`default_nettype none
module ext_pin_model (
  input wire logic [8:0] pin_out, // device drive level
  input wire logic [8:0] pin_oe, // device drive enable
  input wire logic [8:0] ext_lvl, // outside driver level
  input wire logic [8:0] ext_oe, // outside driver enable
  output logic [8:0] pin_in // resolved pin level
);
  // open drain only ever enables a low drive, so the pull-up gives the high level
  always_comb begin
    for (int i = 0; i < 9; i++) begin
      pin_in[i] = pin_oe[i] ? pin_out[i] : (ext_oe[i] ? ext_lvl[i] : 1'b1);
    end
  end
endmodule
`default_nettype wire

/* File: timer_channel_pin_port_regs_tb_top.sv */
// Purpose: self-checking bench for the timer pin port register block
// Assumes: single AHB-Lite master, word transfers, 200 MHz clock
// Notes: counter and flag inputs are held constant
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin error_cnt++; $display("BAD %0t got %h exp %h", $time, g, e); end end
module timer_channel_pin_port_regs_tb_top;
  import timer_pins_pkg::*;
  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd, cmd_data, group_mode, test_setup;
  logic [8:0] pin_in, pin_out, pin_oe, tl_out, tl_oe, tl_in, ext_lvl, ext_oe;
  logic [2:0] io_clk_en, timer_clk_en, chan_cmd_pulse;
  logic [95:0] chan_mode, irq_mask, cap_a, cap_b, cmp_c;
  logic group_cmd_pulse, test_cmd_pulse;
  int error_cnt = 0;
  int n_checks = 0;
  logic [7:0] offs [11] = '{8'h08, 8'h18, 8'h38, 8'h48, 8'h58, 8'h64, 8'h7c, 8'h84, 8'h88, 8'h8c, 8'h0c};
  assign hready = hreadyout;
  timer_pin_port dut (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .timer_line_out(tl_out), .timer_line_oe(tl_oe),
    .timer_line_in(tl_in), .count_now_in({16'h3333, 16'h2222, 16'h1111}), .flags_in(96'h0),
    .io_clk_en(io_clk_en), .timer_clk_en(timer_clk_en), .chan_mode(chan_mode), .irq_mask(irq_mask),
    .cap_cmp_a(cap_a), .cap_cmp_b(cap_b), .cmp_c(cmp_c), .chan_cmd_pulse(chan_cmd_pulse),
    .group_cmd_pulse(group_cmd_pulse), .test_cmd_pulse(test_cmd_pulse), .cmd_data(cmd_data),
    .group_mode(group_mode), .test_setup(test_setup));
  ext_pin_model pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_lvl(ext_lvl), .ext_oe(ext_oe), .pin_in(pin_in));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // address phase held until hready, then data phase held until hready again
  task automatic xfer(input logic w, input int ch, input logic [11:0] off, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= BLOCK_BASE + ch * CH_STRIDE + {20'h0, off};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    #1;
  endtask
  task automatic rchk(input int ch, input logic [11:0] off, input logic [31:0] e);
    xfer(1'b0, ch, off, 32'h0);
    `CHK(rd, e)
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    final_report;
  end
  initial begin
    rstn = 1'b0; hsel = 1'b0; htrans = 2'h0; hwrite = 1'b0; hsize = 3'h2; haddr = 32'h0; hwdata = 32'h0;
    tl_out = 9'h1ff; tl_oe = 9'h0db; ext_lvl = 9'h000; ext_oe = 9'h000;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    for (int c = 0; c < 3; c++) begin
      for (int i = 0; i < 11; i++) rchk(c, {4'h0, offs[i]}, (i == 0) ? 32'h00070000 : 32'h0);
      rchk(c, 12'h000, 32'h0);
    end
    rchk(0, 12'h304, 32'h0);
    rchk(0, 12'h404, 32'h0);
    $display("test reset values done");
    xfer(1'b1, 1, 12'h010, 32'h00050000);
    xfer(1'b1, 1, 12'h030, 32'h00070000);
    xfer(1'b1, 1, 12'h034, 32'h00040000);
    `CHK(pin_oe[5:3], 3'b101)
    `CHK(pin_out[5:3], 3'b011)
    rchk(1, 12'h018, 32'h00050000);
    rchk(1, 12'h038, 32'h00030000);
    rchk(0, 12'h018, 32'h0);
    xfer(1'b1, 1, 12'h014, 32'h00010000);
    rchk(1, 12'h018, 32'h00040000);
    xfer(1'b1, 1, 12'h010, 32'h00010000);
    $display("test direction and level done");
    xfer(1'b1, 1, 12'h040, 32'h00070000);
    `CHK(pin_out[5:3], 3'b000)
    `CHK(pin_oe[5:3], 3'b100)
    rchk(1, 12'h048, 32'h00070000);
    xfer(1'b1, 1, 12'h044, 32'h00070000);
    rchk(1, 12'h048, 32'h0);
    $display("test open drain done");
    xfer(1'b1, 1, 12'h004, 32'h00040000);
    `CHK(pin_oe[5:3], 3'b001)
    `CHK(pin_out[5:3], 3'b111)
    rchk(1, 12'h008, 32'h00030000);
    xfer(1'b1, 1, 12'h000, 32'h0);
    xfer(1'b1, 1, 12'h004, 32'h0);
    rchk(1, 12'h008, 32'h00030000);
    xfer(1'b1, 1, 12'h000, 32'h00040000);
    `CHK(pin_oe[5:3], 3'b101)
    `CHK(pin_out[5:3], 3'b011)
    $display("test ownership done");
    xfer(1'b1, 1, 12'h050, 32'h00000001);
    ext_oe <= 9'h010;
    repeat (4) @(posedge clk);
    rchk(1, 12'h03c, 32'h00010000);
    ext_oe <= 9'h000;
    repeat (4) @(posedge clk);
    rchk(1, 12'h03c, 32'h00030000);
    `CHK(tl_in[5:3], 3'b011)
    xfer(1'b1, 2, 12'h050, 32'h00000003);
    `CHK({io_clk_en[2], timer_clk_en[2]}, 2'b11)
    xfer(1'b1, 2, 12'h054, 32'h00000002);
    `CHK({io_clk_en[2], timer_clk_en[2]}, 2'b10)
    rchk(2, 12'h058, 32'h00000001);
    $display("test pins and clocks done");
    xfer(1'b1, 2, 12'h084, 32'h0000abcd);
    xfer(1'b1, 2, 12'h08c, 32'h00001234);
    rchk(2, 12'h084, 32'h0000abcd);
    rchk(2, 12'h08c, 32'h00001234);
    `CHK(cap_a[95:64], 32'h0000abcd)
    `CHK(cmp_c[95:64], 32'h00001234)
    xfer(1'b1, 2, 12'h088, 32'h00005678);
    rchk(2, 12'h088, 32'h00005678);
    `CHK(cap_b[95:64], 32'h00005678)
    xfer(1'b1, 0, 12'h064, 32'h00008001);
    xfer(1'b1, 0, 12'h074, 32'h00000011);
    `CHK({chan_mode[31:0], irq_mask[31:0]}, {32'h00008001, 32'h00000011})
    rchk(0, 12'h064, 32'h00008001);
    rchk(0, 12'h070, 32'h0);
    xfer(1'b1, 0, 12'h078, 32'h00000001);
    rchk(0, 12'h07c, 32'h00000010);
    xfer(1'b1, 2, 12'h060, 32'h00000004);
    `CHK({chan_cmd_pulse, cmd_data}, {3'b100, 32'h00000004})
    `CHK(hresp, 1'b0)
    xfer(1'b1, 1, 12'h080, 32'h00005555);
    rchk(1, 12'h080, 32'h00002222);
    xfer(1'b1, 0, 12'h304, 32'h000000a5);
    rchk(0, 12'h304, 32'h000000a5);
    xfer(1'b1, 0, 12'h300, 32'h00000002);
    `CHK({group_cmd_pulse, cmd_data}, {1'b1, 32'h00000002})
    rchk(0, 12'h300, 32'h0);
    `CHK(group_mode, 32'h000000a5)
    xfer(1'b1, 0, 12'h404, 32'h0000005a);
    rchk(0, 12'h404, 32'h0000005a);
    `CHK(test_setup, 32'h0000005a)
    xfer(1'b1, 0, 12'h400, 32'h00000009);
    `CHK({test_cmd_pulse, cmd_data}, {1'b1, 32'h00000009})
    $display("test data registers done");
    xfer(1'b1, 0, 12'h010, 32'h00040000);
    xfer(1'b1, 0, 12'h014, 32'h00040000);
    xfer(1'b1, 0, 12'h010, 32'h00010000);
    xfer(1'b1, 0, 12'h030, 32'h00010000);
    xfer(1'b1, 0, 12'h000, 32'h00010000);
    `CHK({pin_oe[0], pin_out[0]}, 2'b11)
    xfer(1'b1, 0, 12'h040, 32'h00010000);
    xfer(1'b1, 0, 12'h004, 32'h00020000);
    `CHK({pin_oe[1:0], pin_out[1:0]}, 4'b1010)
    xfer(1'b1, 0, 12'h050, 32'h00000001);
    repeat (4) @(posedge clk);
    rchk(0, 12'h03c, 32'h00070000);
    rchk(0, 12'h008, 32'h00050000);
    $display("test channel 0 lines done");
    final_report;
  end
endmodule
`default_nettype wire

/* File: timer_pin_port.sv */
// Purpose: register block of three timer channels, with the per-channel pin controller
// Assumes: single clock, AHB-Lite slave, pins taken as synchronous to clk
// Notes: counter, capture and waveform logic live outside; this block stores and steers
`timescale 1ns/1ps
`default_nettype none

// Contract
// - three channels with identical register sets sit at 0x100 steps from the first channel base.
// - a 1 in owner-set hands that line to the general I/O, a 1 in owner-clear gives it back to the timer.
// - owner state reads 1 for I/O-held lines and 0 for timer-held ones, and all three start under I/O.
// - a 1 in output-enable-set makes the line an output, a 1 in output-enable-clear makes it an input.
// - output-enable state reads 1 per output line and resets to all zeros.
// - a 1 in level-set programs output level 1, a 1 in level-clear programs level 0.
// - level state reads back the programmed levels and resets to zero.
// - pin state reads the actual level present on each of the three pins; the code reads a sampled copy that moves only while gate bit 0 is on.
// - open-drain set and clear are write-only and open-drain state reads back, resetting to zero.
// - an open-drain bit at 1 lets the pin only pull low, at 0 the pin drives both levels.
// - clock gate on and off are write-only and gate state reads back, resetting to zero.
// - gate bit 0 enables the I/O controller clock and bit 1 the timer and divider clock.
// - each channel holds read-write registers A, B and C and a read-only counter value, reset to zero.
// - shared group command and test command are write-only, group mode and test setup read-write.
module timer_pin_port
  import timer_pins_pkg::*;
(
  input wire logic clk, // core clock
  input wire logic rstn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write when high
  input wire logic [2:0] hsize, // word only
  input wire logic [31:0] hwdata, // write data
  input wire logic hready, // bus ready
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic [31:0] hrdata, // read data
  input wire logic [timer_pins_pkg::NUM_PINS-1:0] pin_in, // pin levels, 3 per channel
  output logic [timer_pins_pkg::NUM_PINS-1:0] pin_out, // pin drive level
  output logic [timer_pins_pkg::NUM_PINS-1:0] pin_oe, // pin drive enable
  input wire logic [timer_pins_pkg::NUM_PINS-1:0] timer_line_out, // timer drive level
  input wire logic [timer_pins_pkg::NUM_PINS-1:0] timer_line_oe, // timer drive enable
  output logic [timer_pins_pkg::NUM_PINS-1:0] timer_line_in, // sampled pins to timer
  input wire logic [timer_pins_pkg::NUM_CH*timer_pins_pkg::COUNT_W-1:0] count_now_in, // counters
  input wire logic [timer_pins_pkg::NUM_CH*32-1:0] flags_in, // channel flags
  output logic [timer_pins_pkg::NUM_CH-1:0] io_clk_en, // i/o controller clock on
  output logic [timer_pins_pkg::NUM_CH-1:0] timer_clk_en, // timer clock on
  output logic [timer_pins_pkg::NUM_CH*32-1:0] chan_mode, // channel mode words
  output logic [timer_pins_pkg::NUM_CH*32-1:0] irq_mask, // irq enable state
  output logic [timer_pins_pkg::NUM_CH*32-1:0] cap_cmp_a, // register a
  output logic [timer_pins_pkg::NUM_CH*32-1:0] cap_cmp_b, // register b
  output logic [timer_pins_pkg::NUM_CH*32-1:0] cmp_c, // register c
  output logic [timer_pins_pkg::NUM_CH-1:0] chan_cmd_pulse, // channel command written
  output logic group_cmd_pulse, // group command written
  output logic test_cmd_pulse, // test command written
  output logic [31:0] cmd_data, // data of last command
  output logic [31:0] group_mode, // group mode word
  output logic [31:0] test_setup // test setup word
);
  import timer_pins_pkg::*;

  function automatic logic chan_hit(input logic [31:0] a);
    chan_hit = (a[31:12] == BLOCK_BASE[31:12]) && (a[11:10] == CHAN_AREA) && (32'(a[9:8]) < NUM_CH);
  endfunction

  function automatic logic group_hit(input logic [31:0] a, input logic [11:0] off);
    group_hit = (a[31:12] == BLOCK_BASE[31:12]) && (a[11:0] == off);
  endfunction

  function automatic int chan_of(input logic [31:0] a);
    chan_of = int'((a - BLOCK_BASE) / CH_STRIDE) % NUM_CH;
  endfunction

  bus_state_t state_r, state_nxt;
  logic [31:0] addr_r, addr_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic addr_take;
  logic wr_en;
  logic [NUM_LINES-1:0] wd;

  // bus phase tracking; reads insert one wait so hrdata comes from a flop
  always_comb begin
    addr_take = hsel && htrans[1] && hready;
    addr_nxt = addr_take ? haddr : addr_r;
    unique case (state_r)
      BUS_RD_WAIT: state_nxt = BUS_RD_DONE;
      BUS_IDLE, BUS_WRITE, BUS_RD_DONE: begin
        if (addr_take) begin
          state_nxt = hwrite ? BUS_WRITE : BUS_RD_WAIT;
        end else begin
          state_nxt = BUS_IDLE;
        end
      end
      default: state_nxt = BUS_IDLE;
    endcase
    wr_en = (state_r == BUS_WRITE);
    wd = hwdata[LINE_LSB +: NUM_LINES];
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= BUS_IDLE;
      addr_r <= WORD_ZERO;
    end else begin
      state_r <= state_nxt;
      addr_r <= addr_nxt;
    end
  end

  // only reads stall: write data is consumed at the end of its single data phase
  // errors are never signalled; unmapped reads give zero and stray writes drop
  assign hreadyout = (state_r != BUS_RD_WAIT);
  assign hresp = 1'b0;
  assign hrdata = rdata_r;

  // per-channel storage, flat with channel-major indexing, then the shared command, group mode and test setup words
  logic [NUM_PINS-1:0] owner_r, owner_nxt;
  logic [NUM_PINS-1:0] oe_r, oe_nxt;
  logic [NUM_PINS-1:0] lvl_r, lvl_nxt;
  logic [NUM_PINS-1:0] od_r, od_nxt;
  logic [GATE_W*NUM_CH-1:0] gate_r, gate_nxt;
  logic [NUM_CH*32-1:0] mode_r, mode_nxt, irq_r, irq_nxt;
  logic [NUM_CH*32-1:0] ra_r, ra_nxt, rb_r, rb_nxt, rc_r, rc_nxt;
  logic [NUM_CH-1:0] ccmd_r, ccmd_nxt;
  logic gcmd_r, gcmd_nxt, tcmd_r, tcmd_nxt;
  logic [31:0] cmd_r, cmd_nxt, gmode_r, gmode_nxt, tset_r, tset_nxt;
  logic seen_wr_r, seen_wr_nxt;

  always_comb begin
    owner_nxt = owner_r;
    oe_nxt = oe_r;
    lvl_nxt = lvl_r;
    od_nxt = od_r;
    gate_nxt = gate_r;
    mode_nxt = mode_r;
    irq_nxt = irq_r;
    ra_nxt = ra_r;
    rb_nxt = rb_r;
    rc_nxt = rc_r;
    ccmd_nxt = '0;
    gcmd_nxt = 1'b0;
    tcmd_nxt = 1'b0;
    cmd_nxt = cmd_r;
    gmode_nxt = gmode_r;
    tset_nxt = tset_r;
    seen_wr_nxt = seen_wr_r | wr_en;
    // set/clear registers only touch bits written as 1
    if (wr_en && chan_hit(addr_r)) begin
      for (int c = 0; c < NUM_CH; c++) begin
        if (chan_of(addr_r) == c) begin
          unique case (addr_r[7:0])
            OFF_OWNER_SET: owner_nxt[c*NUM_LINES +: NUM_LINES] = owner_r[c*NUM_LINES +: NUM_LINES] | wd;
            OFF_OWNER_CLEAR: owner_nxt[c*NUM_LINES +: NUM_LINES] = owner_r[c*NUM_LINES +: NUM_LINES] & ~wd;
            OFF_OE_SET: oe_nxt[c*NUM_LINES +: NUM_LINES] = oe_r[c*NUM_LINES +: NUM_LINES] | wd;
            OFF_OE_CLEAR: oe_nxt[c*NUM_LINES +: NUM_LINES] = oe_r[c*NUM_LINES +: NUM_LINES] & ~wd;
            OFF_LVL_SET: lvl_nxt[c*NUM_LINES +: NUM_LINES] = lvl_r[c*NUM_LINES +: NUM_LINES] | wd;
            OFF_LVL_CLEAR: lvl_nxt[c*NUM_LINES +: NUM_LINES] = lvl_r[c*NUM_LINES +: NUM_LINES] & ~wd;
            OFF_OD_SET: od_nxt[c*NUM_LINES +: NUM_LINES] = od_r[c*NUM_LINES +: NUM_LINES] | wd;
            OFF_OD_CLEAR: od_nxt[c*NUM_LINES +: NUM_LINES] = od_r[c*NUM_LINES +: NUM_LINES] & ~wd;
            OFF_GATE_ON: gate_nxt[c*GATE_W +: GATE_W] = gate_r[c*GATE_W +: GATE_W] | hwdata[GATE_W-1:0];
            OFF_GATE_OFF: gate_nxt[c*GATE_W +: GATE_W] = gate_r[c*GATE_W +: GATE_W] & ~hwdata[GATE_W-1:0];
            OFF_CHAN_MODE: mode_nxt[c*32 +: 32] = hwdata;
            OFF_IRQ_SET: irq_nxt[c*32 +: 32] = irq_r[c*32 +: 32] | hwdata;
            OFF_IRQ_CLEAR: irq_nxt[c*32 +: 32] = irq_r[c*32 +: 32] & ~hwdata;
            OFF_CAP_A: ra_nxt[c*32 +: 32] = hwdata;
            OFF_CAP_B: rb_nxt[c*32 +: 32] = hwdata;
            OFF_CMP_C: rc_nxt[c*32 +: 32] = hwdata;
            OFF_CHAN_CMD: begin
              ccmd_nxt[c] = 1'b1;
              cmd_nxt = hwdata;
            end
            default: begin
            end
          endcase
        end
      end
    end
    if (wr_en && group_hit(addr_r, OFF_GROUP_CMD)) begin
      gcmd_nxt = 1'b1;
      cmd_nxt = hwdata;
    end
    if (wr_en && group_hit(addr_r, OFF_GROUP_MODE)) begin
      gmode_nxt = hwdata;
    end
    if (wr_en && group_hit(addr_r, OFF_TEST_CMD)) begin
      tcmd_nxt = 1'b1;
      cmd_nxt = hwdata;
    end
    if (wr_en && group_hit(addr_r, OFF_TEST_SETUP)) begin
      tset_nxt = hwdata;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      owner_r <= OWNER_RESET;
      oe_r <= PINS_ZERO;
      lvl_r <= PINS_ZERO;
      od_r <= PINS_ZERO;
      gate_r <= GATE_RESET;
      mode_r <= '0;
      irq_r <= '0;
      ra_r <= '0;
      rb_r <= '0;
      rc_r <= '0;
      ccmd_r <= '0;
      gcmd_r <= 1'b0;
      tcmd_r <= 1'b0;
      cmd_r <= WORD_ZERO;
      gmode_r <= WORD_ZERO;
      tset_r <= WORD_ZERO;
      seen_wr_r <= 1'b0;
    end else begin
      owner_r <= owner_nxt;
      oe_r <= oe_nxt;
      lvl_r <= lvl_nxt;
      od_r <= od_nxt;
      gate_r <= gate_nxt;
      mode_r <= mode_nxt;
      irq_r <= irq_nxt;
      ra_r <= ra_nxt;
      rb_r <= rb_nxt;
      rc_r <= rc_nxt;
      ccmd_r <= ccmd_nxt;
      gcmd_r <= gcmd_nxt;
      tcmd_r <= tcmd_nxt;
      cmd_r <= cmd_nxt;
      gmode_r <= gmode_nxt;
      tset_r <= tset_nxt;
      seen_wr_r <= seen_wr_nxt;
    end
  end

  // pin sampling: timer always sees the pins; the readable copy only moves with the i/o clock on
  logic [NUM_PINS-1:0] sample_r, sample_nxt, pinlvl_r, pinlvl_nxt;

  always_comb begin
    sample_nxt = pin_in;
    pinlvl_nxt = pinlvl_r;
    for (int c = 0; c < NUM_CH; c++) begin
      if (gate_r[c*GATE_W + GATE_IO_BIT]) begin
        pinlvl_nxt[c*NUM_LINES +: NUM_LINES] = sample_r[c*NUM_LINES +: NUM_LINES];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sample_r <= PINS_ZERO;
      pinlvl_r <= PINS_ZERO;
    end else begin
      sample_r <= sample_nxt;
      pinlvl_r <= pinlvl_nxt;
    end
  end

  // rdata holds between reads, so a master that samples late still sees its word
  // read mux, captured in the wait cycle
  always_comb begin
    int c;
    c = chan_of(addr_r);
    rdata_nxt = rdata_r;
    if (state_r == BUS_RD_WAIT) begin
      rdata_nxt = WORD_ZERO;
      if (chan_hit(addr_r)) begin
        unique case (addr_r[7:0])
          OFF_OWNER_STATE: rdata_nxt[LINE_LSB +: NUM_LINES] = owner_r[c*NUM_LINES +: NUM_LINES];
          OFF_OE_STATE: rdata_nxt[LINE_LSB +: NUM_LINES] = oe_r[c*NUM_LINES +: NUM_LINES];
          OFF_LVL_STATE: rdata_nxt[LINE_LSB +: NUM_LINES] = lvl_r[c*NUM_LINES +: NUM_LINES];
          OFF_PIN_STATE: rdata_nxt[LINE_LSB +: NUM_LINES] = pinlvl_r[c*NUM_LINES +: NUM_LINES];
          OFF_OD_STATE: rdata_nxt[LINE_LSB +: NUM_LINES] = od_r[c*NUM_LINES +: NUM_LINES];
          OFF_GATE_STATE: rdata_nxt[GATE_W-1:0] = gate_r[c*GATE_W +: GATE_W];
          OFF_CHAN_MODE: rdata_nxt = mode_r[c*32 +: 32];
          OFF_FLAGS: rdata_nxt = flags_in[c*32 +: 32];
          OFF_IRQ_STATE: rdata_nxt = irq_r[c*32 +: 32];
          OFF_COUNT: rdata_nxt[COUNT_W-1:0] = count_now_in[c*COUNT_W +: COUNT_W];
          OFF_CAP_A: rdata_nxt = ra_r[c*32 +: 32];
          OFF_CAP_B: rdata_nxt = rb_r[c*32 +: 32];
          OFF_CMP_C: rdata_nxt = rc_r[c*32 +: 32];
          default: rdata_nxt = WORD_ZERO;
        endcase
      end else if (group_hit(addr_r, OFF_GROUP_MODE)) begin
        rdata_nxt = gmode_r;
      end else if (group_hit(addr_r, OFF_TEST_SETUP)) begin
        rdata_nxt = tset_r;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rdata_r <= WORD_ZERO;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  // stored i/o direction and level survive timer ownership, so handing a line
  // back restores the last software setting without an extra write
  // pin muxing: owner picks the source, open drain only ever pulls low
  genvar p;
  generate
    for (p = 0; p < NUM_PINS; p++) begin : g_pin
      logic src_d;
      logic src_oe;
      assign src_d = owner_r[p] ? lvl_r[p] : timer_line_out[p];
      assign src_oe = owner_r[p] ? oe_r[p] : timer_line_oe[p];
      assign pin_out[p] = od_r[p] ? 1'b0 : src_d;
      assign pin_oe[p] = src_oe && !(od_r[p] && src_d);
    end
    for (p = 0; p < NUM_CH; p++) begin : g_gate
      assign io_clk_en[p] = gate_r[p*GATE_W + GATE_IO_BIT];
      assign timer_clk_en[p] = gate_r[p*GATE_W + GATE_TMR_BIT];
    end
  endgenerate

  assign timer_line_in = sample_r;
  assign chan_mode = mode_r;
  assign irq_mask = irq_r;
  assign cap_cmp_a = ra_r;
  assign cap_cmp_b = rb_r;
  assign cmp_c = rc_r;
  assign chan_cmd_pulse = ccmd_r;
  assign group_cmd_pulse = gcmd_r;
  assign test_cmd_pulse = tcmd_r;
  assign cmd_data = cmd_r;
  assign group_mode = gmode_r;
  assign test_setup = tset_r;

  logic ch0_wr, ch1_wr;
  assign ch0_wr = wr_en && chan_hit(addr_r) && (addr_r[9:8] == 2'h0);
  assign ch1_wr = wr_en && chan_hit(addr_r) && (addr_r[9:8] == 2'h1);

  chk_owner_set: assert property (@(posedge clk) disable iff (!rstn)
    (ch0_wr && addr_r[7:0] == OFF_OWNER_SET && hwdata[LINE_LSB]) |=> owner_r[0])
    else $error("owner set did not hand line to i/o");
  chk_owner_clear: assert property (@(posedge clk) disable iff (!rstn)
    (ch0_wr && addr_r[7:0] == OFF_OWNER_CLEAR && hwdata[LINE_LSB + LINE_A]) |=> !owner_r[LINE_A])
    else $error("owner clear did not return line to timer");
  chk_zero_keeps: assert property (@(posedge clk) disable iff (!rstn)
    (ch0_wr && addr_r[7:0] == OFF_OE_SET && !hwdata[LINE_LSB]) |=> (oe_r[0] == $past(oe_r[0])))
    else $error("writing zero changed a state bit");
  chk_reset_state: assert property (@(posedge clk) disable iff (!rstn)
    !seen_wr_r |-> (owner_r == OWNER_RESET && oe_r == PINS_ZERO && lvl_r == PINS_ZERO && od_r == PINS_ZERO))
    else $error("line state left its reset value without a write");
  chk_oe_clear: assert property (@(posedge clk) disable iff (!rstn)
    (ch0_wr && addr_r[7:0] == OFF_OE_CLEAR && hwdata[LINE_LSB + LINE_CLK]) |=> !oe_r[LINE_CLK])
    else $error("output disable did not make line an input");
  chk_level_set: assert property (@(posedge clk) disable iff (!rstn)
    (ch0_wr && addr_r[7:0] == OFF_LVL_SET && hwdata[LINE_LSB]) |=> lvl_r[0] &&
      (!(owner_r[0] && oe_r[0] && !od_r[0]) || pin_out[0]))
    else $error("programmed level 1 not driven");
  chk_open_drain: assert property (@(posedge clk) disable iff (!rstn)
    (od_r[0] && owner_r[0] && lvl_r[0]) |-> (!pin_oe[0] && !pin_out[0]))
    else $error("open drain line drove high");
  chk_timer_owns: assert property (@(posedge clk) disable iff (!rstn)
    (!owner_r[1] && !od_r[1]) |-> (pin_out[1] == timer_line_out[1] && pin_oe[1] == timer_line_oe[1]))
    else $error("i/o settings leaked onto a timer line");
  chk_pin_gated: assert property (@(posedge clk) disable iff (!rstn)
    !gate_r[GATE_IO_BIT] |=> $stable(pinlvl_r[NUM_LINES-1:0]))
    else $error("pin state moved with i/o clock off");
  chk_pin_follow: assert property (@(posedge clk) disable iff (!rstn)
    (gate_r[GATE_IO_BIT] && $stable(pin_in[0])) ##1 gate_r[GATE_IO_BIT] |=> pinlvl_r[0] == $past(pin_in[0], 3))
    else $error("pin state did not follow the pin");
  chk_chan_apart: assert property (@(posedge clk) disable iff (!rstn)
    ch1_wr |=> $stable(owner_r[NUM_LINES-1:0]) && $stable(oe_r[NUM_LINES-1:0]))
    else $error("channel 1 write touched channel 0");
  chk_read_wait: assert property (@(posedge clk) disable iff (!rstn)
    (addr_take && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");
endmodule
`default_nettype wire

/* File: timer_pins_pkg.sv */
// Purpose: shared constants for the timer channel pin port register block
// Assumes: 32-bit AHB-Lite register bus, three channels, three lines per channel
// Notes: line bits sit at [18:16] of every line register (b, a, ext clock)
`default_nettype none
package timer_pins_pkg;
  localparam int NUM_CH = 3;
  localparam int NUM_LINES = 3;
  localparam int NUM_PINS = NUM_CH * NUM_LINES;
  localparam int WORD_W = 32;
  localparam int COUNT_W = 16;
  localparam int LINE_LSB = 16;
  localparam int LINE_B = 0;
  localparam int LINE_A = 1;
  localparam int LINE_CLK = 2;
  localparam int GATE_W = 2;
  localparam int GATE_IO_BIT = 0;
  localparam int GATE_TMR_BIT = 1;

  localparam logic [31:0] BLOCK_BASE = 32'hfffc8000;
  localparam logic [31:0] CH_STRIDE = 32'h00000100;
  localparam logic [1:0] CHAN_AREA = 2'h0;

  localparam logic [7:0] OFF_OWNER_SET = 8'h00;
  localparam logic [7:0] OFF_OWNER_CLEAR = 8'h04;
  localparam logic [7:0] OFF_OWNER_STATE = 8'h08;
  localparam logic [7:0] OFF_OE_SET = 8'h10;
  localparam logic [7:0] OFF_OE_CLEAR = 8'h14;
  localparam logic [7:0] OFF_OE_STATE = 8'h18;
  localparam logic [7:0] OFF_LVL_SET = 8'h30;
  localparam logic [7:0] OFF_LVL_CLEAR = 8'h34;
  localparam logic [7:0] OFF_LVL_STATE = 8'h38;
  localparam logic [7:0] OFF_PIN_STATE = 8'h3c;
  localparam logic [7:0] OFF_OD_SET = 8'h40;
  localparam logic [7:0] OFF_OD_CLEAR = 8'h44;
  localparam logic [7:0] OFF_OD_STATE = 8'h48;
  localparam logic [7:0] OFF_GATE_ON = 8'h50;
  localparam logic [7:0] OFF_GATE_OFF = 8'h54;
  localparam logic [7:0] OFF_GATE_STATE = 8'h58;
  localparam logic [7:0] OFF_CHAN_CMD = 8'h60;
  localparam logic [7:0] OFF_CHAN_MODE = 8'h64;
  localparam logic [7:0] OFF_FLAGS = 8'h70;
  localparam logic [7:0] OFF_IRQ_SET = 8'h74;
  localparam logic [7:0] OFF_IRQ_CLEAR = 8'h78;
  localparam logic [7:0] OFF_IRQ_STATE = 8'h7c;
  localparam logic [7:0] OFF_COUNT = 8'h80;
  localparam logic [7:0] OFF_CAP_A = 8'h84;
  localparam logic [7:0] OFF_CAP_B = 8'h88;
  localparam logic [7:0] OFF_CMP_C = 8'h8c;
  localparam logic [11:0] OFF_GROUP_CMD = 12'h300;
  localparam logic [11:0] OFF_GROUP_MODE = 12'h304;
  localparam logic [11:0] OFF_TEST_CMD = 12'h400;
  localparam logic [11:0] OFF_TEST_SETUP = 12'h404;

  localparam logic [NUM_PINS-1:0] OWNER_RESET = 9'h1ff;
  localparam logic [NUM_PINS-1:0] PINS_ZERO = 9'h000;
  localparam logic [GATE_W*NUM_CH-1:0] GATE_RESET = 6'h00;
  localparam logic [31:0] WORD_ZERO = 32'h00000000;

  typedef enum logic [3:0] {
    BUS_IDLE = 4'h1,
    BUS_WRITE = 4'h2,
    BUS_RD_WAIT = 4'h4,
    BUS_RD_DONE = 4'h8
  } bus_state_t;
endpackage
`default_nettype wire
